// file: hdl/sarri_top.sv
/*
  Control and result-output logic of a 16-bit successive-approximation
  converter: conversion start, busy, sample/hold, power-down, result format,
  parallel bus with byte swap and serial output with daisy-chain input.
  Assumes the analog front end presents the held input as a straight binary
  code on analog_code, the data bus pins are resolved outside from out/oe,
  and the host shift clock (the bus bit 11 pin) arrives on serial_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sarri_top
  import sarri_pkg::*;
#(
  parameter int RES_W = RES_BITS
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             serial_clk,
  input  wire logic             conversion_start_n,
  input  wire logic             chip_select_n,
  input  wire logic             power_down_input,
  input  wire logic             bus_format_select,
  input  wire logic             byte_swap_select,
  input  wire logic             input_range_select,
  input  wire logic             code_format_select,
  input  wire logic             reserved_bus_config,
  input  wire logic             reserved_address_pin,
  input  wire logic [RES_W-1:0] analog_code,
  input  wire logic [RES_W-1:0] data_in,
  output logic      [RES_W-1:0] data_out,
  output logic      [RES_W-1:0] data_oe,
  output logic                  busy,
  output logic                  sample_hold,
  output logic                  pseudo_diff_mode,
  output logic                  powered_down
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  logic              cnv_prev_r;
  logic              start_fall;
  logic              start_ok;

  sarri_conv_e       state_r;
  sarri_conv_e       state_nxt;
  logic [7:0]        step_cnt_r;
  logic              step_end;
  logic [RES_W-1:0]  held_r;
  logic [RES_W-1:0]  sar_r;
  logic [RES_W-1:0]  trial_mask_r;
  logic [RES_W-1:0]  trial_code;
  logic              busy_r;
  logic              hold_r;

  logic [RES_W-1:0]  result_r;
  logic [RES_W-1:0]  coded;
  logic [RES_W-1:0]  par_data_r;
  logic [RES_W-1:0]  oe_r;
  logic [RES_W-1:0]  ser_word_r;
  logic              pseudo_r;
  logic              pwdn_r;

  logic              cs_act;
  logic              serial_mode;

  sarri_ser_if ser_bus ();

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  // all control pins arrive asynchronously; only the second stage is read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_r <= SYNC_RST;
      pin_sync_r <= SYNC_RST;
    end else begin
      pin_meta_r <= {code_format_select, input_range_select, byte_swap_select,
                     bus_format_select, power_down_input, chip_select_n,
                     conversion_start_n};
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnv_prev_r <= 1'b1;
    end else begin
      cnv_prev_r <= pin_sync_r[SY_CNV];
    end
  end

  // chip select takes no part in starting a conversion
  assign start_fall  = cnv_prev_r & ~pin_sync_r[SY_CNV];
  // power-down drops requests; a request during a conversion is also dropped
  assign start_ok    = start_fall & ~pin_sync_r[SY_PWDN] & (state_r == CONV_ACQUIRE);
  assign cs_act      = ~pin_sync_r[SY_CS];
  assign serial_mode = (pin_sync_r[SY_FMT] == BUS_SERIAL);

  // ==========================================================================
  // conversion sequencer
  // ==========================================================================
  assign step_end   = (step_cnt_r == 8'(STEP_CYCLES - 1));
  assign trial_code = sar_r | trial_mask_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CONV_ACQUIRE: begin
        if (start_ok) begin
          state_nxt = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (step_end && (trial_mask_r == LSB_MASK)) begin
          state_nxt = CONV_DONE;
        end
      end
      CONV_DONE: begin
        state_nxt = CONV_ACQUIRE;
      end
      default: begin
        state_nxt = CONV_ACQUIRE;
      end
    endcase
  end

  // reset halts a running conversion and returns to acquisition
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= CONV_ACQUIRE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_cnt_r <= 8'h00;
    end else if (state_r != CONV_RUN || step_end) begin
      step_cnt_r <= 8'h00;
    end else begin
      step_cnt_r <= step_cnt_r + 8'h01;
    end
  end

  // track/hold switch: hold from the start edge to the end of conversion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_r <= 1'b0;
      held_r <= RESULT_RST;
    end else if (start_ok) begin
      hold_r <= 1'b1;
      held_r <= analog_code;
    end else if (state_r == CONV_DONE) begin
      hold_r <= 1'b0;
    end
  end

  // binary search, one bit per step, most significant first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sar_r        <= RESULT_RST;
      trial_mask_r <= MSB_MASK;
    end else if (start_ok) begin
      sar_r        <= RESULT_RST;
      trial_mask_r <= MSB_MASK;
    end else if (state_r == CONV_RUN && step_end) begin
      if (held_r >= trial_code) begin
        sar_r <= trial_code;
      end
      trial_mask_r <= trial_mask_r >> 1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (start_ok) begin
      busy_r <= 1'b1;
    end else if (state_r == CONV_DONE) begin
      busy_r <= 1'b0;
    end
  end

  // ==========================================================================
  // result register
  // ==========================================================================
  // loaded in the same edge that drops busy; the bus and serial word registers take it one edge after its fall
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_r <= RESULT_RST;
    end else if (state_r == CONV_DONE) begin
      result_r <= sar_r;
    end
  end

  assign coded = sarri_fmt(result_r, pin_sync_r[SY_CODE]);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pseudo_r <= 1'b0;
      pwdn_r   <= 1'b0;
    end else begin
      pseudo_r <= pin_sync_r[SY_RANGE];
      pwdn_r   <= pin_sync_r[SY_PWDN];
    end
  end

  // ==========================================================================
  // parallel bus
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      par_data_r <= RESULT_RST;
    end else if (pin_sync_r[SY_SWAP]) begin
      par_data_r <= {coded[BYTE_W-1:0], coded[RES_W-1:BYTE_W]};
    end else begin
      par_data_r <= coded;
    end
  end

  // reset clears the enables at once through the asynchronous clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_r <= BUS_OE_NONE;
    end else if (!cs_act) begin
      oe_r <= BUS_OE_NONE;
    end else if (serial_mode) begin
      oe_r <= BUS_OE_SER;
    end else begin
      oe_r <= BUS_OE_ALL;
    end
  end

  // ==========================================================================
  // serial path
  // ==========================================================================
  // the word is frozen while chip select is low, so the shifter loads a
  // settled value; the host must not open a frame before busy falls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser_word_r <= RESULT_RST;
    end else if (!cs_act) begin
      ser_word_r <= coded;
    end
  end

  assign ser_bus.word = ser_word_r;

  sarri_shifter u_shifter (
    .serial_clk        (serial_clk),
    .rst               (rst),
    .chip_select_n     (chip_select_n),
    .daisy_chain_input (data_in[DAISY_PIN]),
    .ser               (ser_bus.shifter)
  );

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_comb begin
    data_out = par_data_r;
    if (serial_mode) begin
      data_out              = RESULT_RST;
      data_out[SER_OUT_PIN] = ser_bus.dout;
    end
  end

  assign data_oe          = oe_r;
  assign busy             = busy_r;
  assign sample_hold      = hold_r;
  assign pseudo_diff_mode = pseudo_r;
  assign powered_down     = pwdn_r;

endmodule : sarri_top

`default_nettype wire

// file: hdl/sarri_pkg.sv
/*
  Shared constants, types and the output-code helper of the converter
  result interface: conversion timing, bus pin positions, pin-synchroniser
  layout and the conversion state enumeration.
  Assumes a 100 MHz system clock and a 16-bit result word.
*/
// Function
// - start falling edge holds sample, starts conversion
// - start acts regardless of chip select
// - busy high during conversion, falls when done
// - data bus driven only while chip select low
// - chip select gates the shift clock
// - reset aborts conversion, floats data bus
// - power-down ignores conversion start requests
// - parallel mode maps bytes, swap optional
// - serial mode uses bits 11, 10, 9
// - serial output MSB first on rising edge
// - daisy input reaches output after 16 clocks
// - range and code format from select pins
// - serial code follows same format selects
// - offset binary is two's complement, MSB inverted
// - byte swap ignored in serial mode
package sarri_pkg;

  // ==========================================================================
  // resolution and timing
  // ==========================================================================
  localparam int          RES_BITS      = 16;
  localparam int          CLK_PERIOD_PS = 10000;
  localparam int          T_CONV_NS     = 320;
  // least time: rounded up to whole system clocks
  localparam int          CONV_CYCLES   = (T_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          STEP_RAW      = CONV_CYCLES / RES_BITS;
  localparam int          STEP_CYCLES   = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam int          DAISY_DELAY   = 16;

  // ==========================================================================
  // data bus layout
  // ==========================================================================
  localparam int          SCK_PIN       = 11;
  localparam int          SER_OUT_PIN   = 10;
  localparam int          DAISY_PIN     = 9;
  localparam int          BYTE_W        = 8;
  localparam logic        BUS_PARALLEL  = 1'b0;
  localparam logic        BUS_SERIAL    = 1'b1;
  localparam logic [15:0] RESULT_RST    = 16'h0000;
  localparam logic [15:0] MSB_MASK      = 16'h8000;
  localparam logic [15:0] LSB_MASK      = 16'h0001;
  localparam logic [15:0] BUS_OE_ALL    = 16'hFFFF;
  localparam logic [15:0] BUS_OE_NONE   = 16'h0000;
  localparam logic [15:0] BUS_OE_SER    = 16'h0400;

  // ==========================================================================
  // pin synchroniser layout
  // ==========================================================================
  localparam int          SY_CNV        = 0;
  localparam int          SY_CS         = 1;
  localparam int          SY_PWDN       = 2;
  localparam int          SY_FMT        = 3;
  localparam int          SY_SWAP       = 4;
  localparam int          SY_RANGE      = 5;
  localparam int          SY_CODE       = 6;
  localparam int          SYNC_W        = 7;
  localparam logic [6:0]  SYNC_RST      = 7'h03;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    CONV_ACQUIRE,
    CONV_RUN,
    CONV_DONE
  } sarri_conv_e;

  // offset/straight binary is the raw code; two's complement flips the msb
  function automatic logic [15:0] sarri_fmt(input logic [15:0] raw,
                                            input logic        binary_code);
    sarri_fmt = binary_code ? raw : (raw ^ MSB_MASK);
  endfunction : sarri_fmt

endpackage : sarri_pkg

// file: hdl/sarri_ser_if.sv
/*
  Carrier between the system-clock core and the shift-clock serial shifter.
  Assumes the word is held stable by the core while a serial frame runs.
*/
`timescale 1ns/1ps
`default_nettype none

interface sarri_ser_if;
  logic [15:0] word;
  logic        dout;

  modport core    (output word, input dout);
  modport shifter (input word, output dout);
endinterface : sarri_ser_if

`default_nettype wire

// file: hdl/sarri_shifter.sv
/*
  Serial result shifter, clocked by the host shift clock.
  Assumes the host keeps chip select stable around shift clock edges and
  lets the clock stand still outside frames.
*/
`timescale 1ns/1ps
`default_nettype none

module sarri_shifter
  import sarri_pkg::*;
(
  input  wire logic  serial_clk,
  input  wire logic  rst,
  input  wire logic  chip_select_n,
  input  wire logic  daisy_chain_input,
  sarri_ser_if.shifter ser
);

  logic        fresh_r;
  logic        out_r;
  logic [15:0] shift_r;

  // ==========================================================================
  // frame start marker
  // ==========================================================================
  // chip select high presets the marker, so no clock edge is needed to arm it
  always_ff @(posedge serial_clk or posedge rst or posedge chip_select_n) begin
    if (rst) begin
      fresh_r <= 1'b1;
    end else if (chip_select_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // ==========================================================================
  // shifter
  // ==========================================================================
  // the daisy bit taken at the load edge leaves after sixteen more edges
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      shift_r <= RESULT_RST;
      out_r   <= 1'b0;
    end else if (!chip_select_n) begin
      if (fresh_r) begin
        out_r   <= ser.word[RES_BITS-1];
        shift_r <= {ser.word[RES_BITS-2:0], daisy_chain_input};
      end else begin
        out_r   <= shift_r[RES_BITS-1];
        shift_r <= {shift_r[RES_BITS-2:0], daisy_chain_input};
      end
    end
  end

  assign ser.dout = out_r;

endmodule : sarri_shifter

`default_nettype wire

// file: tb/sarri_properties.sv
/*
  Port-level checker of the converter result interface.
  Assumes it is bound to sarri_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module sarri_properties
  import sarri_pkg::*;
#(
  parameter int RES_W = RES_BITS
) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             conversion_start_n,
  input wire logic             chip_select_n,
  input wire logic             power_down_input,
  input wire logic             bus_format_select,
  input wire logic             input_range_select,
  input wire logic [RES_W-1:0] data_out,
  input wire logic [RES_W-1:0] data_oe,
  input wire logic             busy,
  input wire logic             sample_hold,
  input wire logic             pseudo_diff_mode,
  input wire logic             powered_down
);
  // ==========================================================================
  // busy length counter
  // ==========================================================================
  logic [7:0] busy_cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busy_cnt_r <= 8'h00;
    else if (busy) busy_cnt_r <= busy_cnt_r + 8'h01;
    else busy_cnt_r <= 8'h00;
  end

  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // the pin synchroniser makes the answer land 3 edges late; the window takes 2 to 4
  sequence s_start;
    $fell(conversion_start_n) && !busy && !power_down_input && !powered_down;
  endsequence
  sequence s_busy_rise;
    ##[2:4] $rose(busy);
  endsequence

  chk_start_busy: assert property (s_start |-> s_busy_rise)
    else $error("start edge did not raise busy");
  chk_busy_len: assert property ($fell(busy) |-> busy_cnt_r == 8'(CONV_CYCLES + 1))
    else $error("busy span wrong");
  chk_hold_span: assert property (sample_hold == busy)
    else $error("hold differs from busy");
  chk_cs_float: assert property (chip_select_n [*5] |-> data_oe == BUS_OE_NONE)
    else $error("bus driven with chip select high");
  chk_par_oe: assert property ((!chip_select_n && !bus_format_select) [*5] |-> data_oe == BUS_OE_ALL)
    else $error("parallel bus not driven");
  chk_ser_pins: assert property ((!chip_select_n && bus_format_select) [*5]
    |-> data_oe == BUS_OE_SER && (data_out & ~BUS_OE_SER) == 16'h0000)
    else $error("serial pin use wrong");
  chk_pwdn_refuse: assert property (power_down_input [*6] |-> powered_down && !$rose(busy))
    else $error("start taken in power down");
  chk_range_copy: assert property ($stable(input_range_select) [*5]
    |-> pseudo_diff_mode == input_range_select)
    else $error("range select not followed");
  chk_reset_idle: assert property ($fell(rst) |-> data_oe == BUS_OE_NONE && !busy)
    else $error("not idle after reset");
endmodule : sarri_properties

bind sarri_top sarri_properties #(.RES_W(RES_W)) u_sarri_properties (
  .sys_clk, .rst, .conversion_start_n, .chip_select_n, .power_down_input, .bus_format_select,
  .input_range_select, .data_out, .data_oe, .busy, .sample_hold, .pseudo_diff_mode, .powered_down
);

`default_nettype wire

// file: tb/sarri_host_model.sv
/*
  Host side of the serial link: shift clock and result capture.
  Assumes the bench resolves the bus pins and calls shift per frame.
*/
`timescale 1ns/1ps
`default_nettype none

module sarri_host_model (
  input  wire logic        ser_bit,
  output logic             sck,
  output logic      [31:0] cap
);
  initial begin
    sck = 1'b0;
    cap = 32'h00000000;
  end

  // clock stands still between calls; bit taken half a period after launch
  task automatic shift(input int n);
    #3; // keeps the link clock out of step with the system clock
    repeat (n) begin
      #15 sck = 1'b1;
      #15 sck = 1'b0;
      cap = {cap[30:0], ser_bit};
    end
  endtask : shift
endmodule : sarri_host_model

`default_nettype wire

// file: tb/test_sar_adc_result_interface.sv
/*
  Self-checking bench of the converter result interface.
  Assumes sarri_top, the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module test_sar_adc_result_interface
  import sarri_pkg::*;
;
  logic        sys_clk = 1'b0, rst = 1'b1, conversion_start_n = 1'b1, chip_select_n = 1'b1;
  logic        power_down_input = 1'b0, bus_format_select = 1'b0, byte_swap_select = 1'b0;
  logic        input_range_select = 1'b0, code_format_select = 1'b0, daisy = 1'b0;
  logic        reserved_bus_config = 1'b0, reserved_address_pin = 1'b0;
  logic [15:0] analog_code = 16'h0000, host_bus = 16'h0000, expr;
  logic [15:0] exp_q[$];
  wire  [15:0] data_in, data_out, data_oe, hb;
  wire  [31:0] cap;
  wire         busy, sample_hold, pseudo_diff_mode, powered_down, sck, serial_clk;
  int          failures = 0, compares = 0, cycles = 0, seed = 67756;

  // ==========================================================================
  // pins, design and host
  // ==========================================================================
  assign hb         = {host_bus[15:12], sck, host_bus[10], daisy, host_bus[8:0]};
  assign data_in    = (data_out & data_oe) | (hb & ~data_oe);
  assign serial_clk = data_in[11];

  sarri_top u_sarri_top (
    .sys_clk, .rst, .serial_clk, .conversion_start_n, .chip_select_n, .power_down_input,
    .bus_format_select, .byte_swap_select, .input_range_select, .code_format_select,
    .reserved_bus_config, .reserved_address_pin, .analog_code, .data_in, .data_out, .data_oe,
    .busy, .sample_hold, .pseudo_diff_mode, .powered_down
  );
  sarri_host_model u_host (.ser_bit(data_in[SER_OUT_PIN]), .sck(sck), .cap(cap));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task test_done;
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task wait_busy(input logic lvl);
    int i;
    i = 0;
    while (busy !== lvl && i < 60) begin
      @(posedge sys_clk);
      i++;
    end
    `CHK(busy, lvl)
  endtask : wait_busy

  task pulse_start;
    @(posedge sys_clk) conversion_start_n <= 1'b0;
    tick(3);
    conversion_start_n <= 1'b1;
  endtask : pulse_start

  // a second start during busy must leave the first sample in place
  task conv(input logic [15:0] val);
    @(posedge sys_clk) analog_code <= val;
    pulse_start();
    wait_busy(1'b1);
    analog_code <= 16'($random(seed));
    pulse_start();
    wait_busy(1'b0);
    exp_q.push_back(code_format_select ? val : val ^ MSB_MASK);
    expr = exp_q.pop_front();
  endtask : conv

  task cs(input logic lvl);
    @(posedge sys_clk) chip_select_n <= lvl;
    tick(5);
  endtask : cs

  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(4);
    `CHK(data_oe, BUS_OE_NONE)
    for (int m = 0; m < 8; m++) begin
      @(posedge sys_clk) {byte_swap_select, input_range_select, code_format_select} <= m[2:0];
      tick(4);
      conv(16'($random(seed)));
      cs(1'b0);
      `CHK(data_oe, BUS_OE_ALL)
      `CHK(data_out, byte_swap_select ? {expr[7:0], expr[15:8]} : expr)
      `CHK(pseudo_diff_mode, input_range_select)
      cs(1'b1);
      `CHK(data_oe, BUS_OE_NONE)
    end
    // last result already read before power down
    @(posedge sys_clk) power_down_input <= 1'b1;
    tick(5);
    pulse_start();
    tick(10);
    `CHK(busy, 1'b0)
    `CHK(powered_down, 1'b1)
    power_down_input <= 1'b0;
    cs(1'b0);
    `CHK(data_out, {expr[7:0], expr[15:8]})
    cs(1'b1);
    @(posedge sys_clk) bus_format_select <= 1'b1;
    tick(4);
    for (int f = 0; f < 4; f++) begin
      @(posedge sys_clk) {byte_swap_select, code_format_select} <= f[1:0];
      input_range_select <= 1'($random(seed));
      host_bus <= 16'($random(seed));
      daisy <= 1'($random(seed));
      tick(4);
      conv(16'($random(seed)));
      u_host.shift(5);
      cs(1'b0);
      `CHK(data_oe, BUS_OE_SER)
      u_host.shift(32);
      `CHK(cap[31:16], expr)
      `CHK(cap[15:0], {16{daisy}})
      cs(1'b1);
    end
    cs(1'b0);
    pulse_start();
    wait_busy(1'b1);
    tick(5);
    rst <= 1'b1;
    tick(2);
    `CHK(busy, 1'b0)
    `CHK(data_oe, BUS_OE_NONE)
    rst <= 1'b0;
    tick(5);
    `CHK(data_oe, BUS_OE_SER)
    test_done();
  end
endmodule : test_sar_adc_result_interface

`default_nettype wire
